// ==== verilog/pwr_rst_pkg.sv ====
// package for the system power and reset control block
// assumes a single 50 MHz system clock domain
package pwr_rst_pkg;

  localparam int unsigned SYNC_STAGES   = 2;
  localparam int unsigned CLK_PERIOD_NS = 20;

  // power states
  typedef enum logic [1:0] {
    PWR_OFF     = 2'b00,
    PWR_WAKE    = 2'b01,
    PWR_ON      = 2'b10,
    PWR_SHUTOFF = 2'b11
  } pwr_state_e;

  // synchronised pin inputs
  typedef struct packed {
    logic on_button;
    logic supply_good;
    logic supply_change_irq;
    logic expansion_attach_irq_in;
  } pin_in_s;

  // event pulses to software
  typedef struct packed {
    logic emergency;
    logic supply_change;
    logic expansion;
  } event_s;

  localparam logic [3:0] PIN_RESET = 4'h0;

endpackage

// ==== verilog/sync_cell.sv ====
// two flop level synchroniser for one pin input
// assumes the input is asynchronous to clk_sys_i
`timescale 1ns/100ps
module sync_cell (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_q;
  logic sync_q;

  // meta_q feeds only sync_q
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // sync_cell

// ==== verilog/system_power_reset_control.sv ====
// system power, reset and supply select control
// assumes pins arrive asynchronously; the supply owns its rails
// Function
// - expansion attach input raises an interrupt event
// - low core reset input resets the core
// - on button sets supply select
// - no on-button select while supply good low
// - no wake select while off, supply bad
// - supply select frames serial supply commands
// - supply good loss while running is emergency
// - supply change reported as low priority event
`timescale 1ns/100ps
module system_power_reset_control (
  input  wire logic                     clk_sys_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     power_on_reset_n_i,
  input  wire logic                     core_reset_n_i,
  input  wire logic                     on_button_i,
  input  wire logic                     supply_good_i,
  input  wire logic                     supply_change_irq_i,
  input  wire logic                     expansion_attach_irq_in_i,
  input  wire logic                     wake_req_i,
  input  wire logic                     power_off_req_i,
  input  wire logic                     spi_frame_i,
  output logic                          supply_select_o,
  output logic                          core_reset_o,
  output logic                          system_on_o,
  output pwr_rst_pkg::event_s           event_o,
  output pwr_rst_pkg::pwr_state_e       state_o
);
  import pwr_rst_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic       button_syn;
  logic       good_syn;
  logic       change_syn;
  logic       exp_syn;
  logic       por_syn;
  logic       core_syn;
  pin_in_s    pin;

  // one two flop cell per pin; nothing reads the first flop
  sync_cell u_sync_button (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (on_button_i),
    .sync_o    (button_syn)
  );

  sync_cell u_sync_good (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (supply_good_i),
    .sync_o    (good_syn)
  );

  sync_cell u_sync_change (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (supply_change_irq_i),
    .sync_o    (change_syn)
  );

  sync_cell u_sync_exp (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (expansion_attach_irq_in_i),
    .sync_o    (exp_syn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset sources, inverted so the cells reset to the idle level

  sync_cell u_sync_por (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (~power_on_reset_n_i),
    .sync_o    (por_syn)
  );

  sync_cell u_sync_core (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (~core_reset_n_i),
    .sync_o    (core_syn)
  );

  assign pin = {button_syn,
                good_syn,
                change_syn,
                exp_syn};

  ////////////////////////////////////////////////////////////////////////////
  // edge detection

  pin_in_s    prev_q;
  logic       por_active;
  logic       button_rise;
  logic       good_fall;
  logic       change_rise;
  logic       exp_edge;

  // same reset level as the sync cells, so no false edge after reset
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_q <= pin_in_s'(PIN_RESET);
    end else begin
      prev_q <= pin;
    end
  end

  assign por_active  = por_syn;
  assign button_rise = pin.on_button & ~prev_q.on_button;
  assign good_fall   = ~pin.supply_good & prev_q.supply_good;
  assign change_rise = pin.supply_change_irq & ~prev_q.supply_change_irq;
  // attach, detach and peripheral interrupt all show as a change
  assign exp_edge    = pin.expansion_attach_irq_in ^ prev_q.expansion_attach_irq_in;

  ////////////////////////////////////////////////////////////////////////////
  // power state machine

  pwr_state_e state_q;
  pwr_state_e state_d;
  logic       wake_ok;

  // both on-button and wake attempts need supply good
  assign wake_ok = (button_rise | wake_req_i) & pin.supply_good;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PWR_OFF: begin
        if (wake_ok) begin
          state_d = PWR_WAKE;
        end
      end
      PWR_WAKE: begin
        state_d = PWR_ON;
      end
      PWR_ON: begin
        if (power_off_req_i) begin
          state_d = PWR_SHUTOFF;
        end
      end
      PWR_SHUTOFF: begin
        state_d = PWR_OFF;
      end
    endcase
  end

  // power-on reset wins over any request in flight
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= PWR_OFF;
    end else if (por_active) begin
      state_q <= PWR_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic   running;
  logic   select_d;
  logic   select_q;
  logic   core_rst_d;
  logic   core_rst_q;
  logic   emergency_d;
  logic   change_d;
  logic   expansion_d;
  event_s event_d;
  event_s event_q;

  assign running = (state_q == PWR_ON);

  // wake pulse, then serial frames reuse the same select
  assign select_d   = (state_d == PWR_WAKE) | (running & spi_frame_i);
  assign core_rst_d = core_syn | por_active;

  // emergency only while on: an off system has nothing to shut down
  assign emergency_d = running & good_fall;
  assign change_d    = change_rise;
  assign expansion_d = exp_edge;
  assign event_d     = {emergency_d, change_d, expansion_d};

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      select_q <= 1'b0;
    end else begin
      select_q <= select_d;
    end
  end

  // core held in reset until sys_rst_i falls, then follows the synchronised reset pins, whose cells reset to released
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= core_rst_d;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      event_q <= '0;
    end else begin
      event_q <= event_d;
    end
  end

  assign supply_select_o = select_q;
  assign core_reset_o    = core_rst_q;
  assign system_on_o     = running;
  assign event_o         = event_q;
  assign state_o         = state_q;
endmodule // system_power_reset_control

// ==== verif/system_power_reset_control_checker.sv ====
// port assertions for the power control block
// assumes two sync flops plus an edge stage on pins
`timescale 1ns/100ps
module pwr_checker
  import pwr_rst_pkg::*;
(
  input logic       clk_sys_i, sys_rst_i, core_reset_n_i, on_button_i, supply_good_i,
  input logic       supply_change_irq_i, expansion_attach_irq_in_i, power_off_req_i,
  input logic       spi_frame_i, supply_select_o, core_reset_o, system_on_o,
  input event_s     event_o,
  input pwr_state_e state_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence press; $rose(on_button_i) && state_o == PWR_OFF; endsequence
  btn_wake_a: assert property (supply_good_i [*4] ##0 press |-> ##[2:6] supply_select_o)
    else $error("no wake");
  sync_edge_a: assert property (press |=> !supply_select_o) else $error("early");
  bad_good_a: assert property (!supply_good_i [*5]
    |-> !$rose(supply_select_o) || system_on_o) else $error("bad wake");
  core_rst_a: assert property (!core_reset_n_i [*4] |-> core_reset_o)
    else $error("no reset");
  emerg_ev_a: assert property (system_on_o && $fell(supply_good_i)
    |-> ##[1:6] event_o.emergency) else $error("no emergency");
  change_ev_a: assert property ($rose(supply_change_irq_i)
    |-> ##[1:6] event_o.supply_change) else $error("no change");
  attach_ev_a: assert property ($changed(expansion_attach_irq_in_i)
    |-> ##[1:6] event_o.expansion) else $error("no attach");
  frame_sel_a: assert property (system_on_o && spi_frame_i && !power_off_req_i
    |=> supply_select_o) else $error("no frame");
endmodule // pwr_checker
bind system_power_reset_control pwr_checker pwr_checker_inst (.*);

// ==== verif/supply_model.sv ====
// behavioural system supply on the select pin
// assumes the bench sets the good level it reports
`timescale 1ns/100ps
module supply_model (
  input  logic select_i,
  input  logic good_cmd_i,
  output logic supply_good_o,
  output logic rail_on_o = 1'h0,
  output int   cmds_o = 0
);
  assign supply_good_o = good_cmd_i;
  always @(posedge select_i) rail_on_o <= 1'h1;
  always @(negedge select_i) cmds_o <= cmds_o + 1;
endmodule // supply_model

// ==== verif/test_system_power_reset_control.sv ====
// bench for system_power_reset_control
// assumes supply_model answers on the select pin
`timescale 1ns/100ps
module test_system_power_reset_control;
  import pwr_rst_pkg::*;
  logic clk_sys_i = 1'h0, sys_rst_i = 1'h1, supply_good_i, good, rail, supply_select_o;
  logic power_on_reset_n_i, core_reset_n_i, on_button_i, supply_change_irq_i, wake_req_i;
  logic expansion_attach_irq_in_i, power_off_req_i, spi_frame_i, core_reset_o, system_on_o;
  logic [8:0] pins = 9'h0a0;
  event_s     event_o, seen;
  pwr_state_e state_o;
  int         fail_count = 0, checks_done = 0, cmds, c;
  // one vector so each step sets every pin at once
  assign {power_on_reset_n_i, core_reset_n_i, on_button_i, good, supply_change_irq_i,
    expansion_attach_irq_in_i, wake_req_i, power_off_req_i, spi_frame_i} = pins;
  system_power_reset_control system_power_reset_control_inst (.*);
  supply_model supply_model_inst (.select_i(supply_select_o), .good_cmd_i(good),
    .supply_good_o(supply_good_i), .rail_on_o(rail), .cmds_o(cmds));
  initial forever #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) seen <= seen | event_o;
  task automatic set(input logic [8:0] v, input int n);
    pins <= v;
    #1 seen = '0;
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic chk(input string n, input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) $display("unexpected %s exp %h got %h", n, exp, got);
    if (got !== exp) fail_count++;
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic power_up;
    c = cmds;
    set(9'h1e0, 8);
    set(9'h1a0, 1);
    chk("state", state_o, PWR_ON);
    chk("on", system_on_o, 1'h1);
    chk("rail", rail, 1'h1);
    set(9'h1a1, 1);
    set(9'h1a0, 3);
    chk("frames", 4'(cmds - c), 4'h2);
    $display("power up done");
  endtask
  task automatic pin_events;
    set(9'h138, 8);
    chk("change", seen.supply_change, 1'h1);
    chk("attach", seen.expansion, 1'h1);
    chk("core", core_reset_o, 1'h1);
    set(9'h198, 8);
    chk("emergency", seen.emergency, 1'h1);
    $display("events done");
  endtask
  task automatic refusals;
    set(9'h19a, 1);
    set(9'h198, 6);
    chk("off", state_o, PWR_OFF);
    set(9'h1dc, 8);
    chk("stay off", state_o, PWR_OFF);
    $display("refusals done");
  endtask
  task automatic wake_and_por;
    set(9'h199, 3);
    chk("idle select", supply_select_o, 1'h0);
    set(9'h1a0, 3);
    set(9'h1a4, 1);
    set(9'h1a0, 2);
    chk("wake", state_o, PWR_ON);
    set(9'h0a0, 4);
    chk("por off", state_o, PWR_OFF);
    chk("por core", core_reset_o, 1'h1);
    $display("wake and por done");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    set(9'h0a0, 2);
    set(9'h1a0, 4);
    power_up();
    pin_events();
    refusals();
    wake_and_por();
    wrap_up();
  end
  initial begin
    repeat (500) @(posedge clk_sys_i);
    fail_count++;
    wrap_up();
  end
endmodule // test_system_power_reset_control
